// ### rtl/acb_pkg.sv
// constants and state type for the record-path coefficient banks
package acb_pkg;

  // ----------------------------------------------------------------
  // page and register layout
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_SEL_REG    = 8'h00;
  localparam logic [7:0] BANK0_PAGE      = 8'h08;  // pages 8 to 16
  localparam logic [7:0] BANK1_PAGE      = 8'h1A;  // pages 26 to 34
  localparam logic [7:0] PAGES_PER_BANK  = 8'h09;
  localparam logic [6:0] FIRST_COEF_REG  = 7'h08;
  localparam logic [4:0] FIRST_COEF_SLOT = 5'h02;  // register 8 over 4
  localparam logic [11:0] COEFS_PER_PAGE = 12'h01E; // 30 slots a page
  localparam logic [11:0] LAST_INDEX     = 12'h0FF;
  localparam int          NUM_COEFS      = 256;

  // byte lanes inside a four-register slot
  localparam logic [1:0] LANE_HI   = 2'h0;  // bits 23:16
  localparam logic [1:0] LANE_MID  = 2'h1;  // bits 15:8
  localparam logic [1:0] LANE_LO   = 2'h2;  // bits 7:0
  localparam logic [1:0] LANE_RSVD = 2'h3;  // reserved byte

  // ----------------------------------------------------------------
  // reset values; the 24-bit coefficient is bits 31:8 of the value
  // ----------------------------------------------------------------
  localparam logic [7:0]  PAGE_RESET = 8'h00;
  localparam logic [31:0] DEF_ZERO   = 32'h00000000;
  localparam logic [31:0] DEF_A      = 32'h01170000;
  localparam logic [31:0] DEF_B      = 32'h7DD30000;
  localparam logic [31:0] DEF_C      = 32'h07FFFF00;

  typedef logic [NUM_COEFS-1:0][23:0] acb_bank_t;

  // default contents, identical for both banks
  function automatic acb_bank_t acb_default_bank();
    acb_bank_t b;
    b = '0;
    for (int i = 0; i < NUM_COEFS; i++)
    begin
      case (i)
        1, 2:    b[i] = DEF_A[31:8];
        3:       b[i] = DEF_B[31:8];
        4, 7, 12, 17, 22, 27, 36, 39, 44, 49, 54, 59:
                 b[i] = DEF_C[31:8];
        default: b[i] = DEF_ZERO[31:8];
      endcase
    end
    return b;
  endfunction : acb_default_bank

  localparam acb_bank_t BANK_RESET = acb_default_bank();

  // whole state of the top module
  typedef struct packed {
    logic [7:0]            page;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic [23:0]           cdata;
    logic [1:0][NUM_COEFS-1:0][23:0] coef;
  } acb_state_t;

endpackage : acb_pkg

// ### rtl/acb_dec_if.sv
// page and register decode signals between the bank and its decoder
`timescale 1ns/100ps
interface acb_dec_if;
  logic [7:0] page;
  logic [6:0] regaddr;
  logic       hit;
  logic       bank;
  logic [7:0] index;
  logic [1:0] lane;

  modport dec  (input page, input regaddr,
                output hit, output bank, output index, output lane);
  modport user (output page, output regaddr,
                input hit, input bank, input index, input lane);
endinterface : acb_dec_if

// ### rtl/acb_decode.sv
// maps page and register number onto bank, coefficient index and lane
`timescale 1ns/100ps
module acb_decode (
  // decode request and result
  acb_dec_if.dec d
);

  logic [7:0]  rel;
  logic        in0;
  logic        in1;
  logic [4:0]  slot;
  logic [11:0] idx_w;

  // ----------------------------------------------------------------
  // page to bank, slot to index
  // ----------------------------------------------------------------
  always_comb
  begin
    in0   = (d.page >= acb_pkg::BANK0_PAGE) &&
            (d.page < acb_pkg::BANK0_PAGE + acb_pkg::PAGES_PER_BANK);
    in1   = (d.page >= acb_pkg::BANK1_PAGE) &&
            (d.page < acb_pkg::BANK1_PAGE + acb_pkg::PAGES_PER_BANK);
    rel   = in1 ? 8'(d.page - acb_pkg::BANK1_PAGE)
                : 8'(d.page - acb_pkg::BANK0_PAGE);
    slot  = 5'(d.regaddr[6:2] - acb_pkg::FIRST_COEF_SLOT);
    // thirty slots a page, counted on from the bank's first page
    idx_w = 12'(12'(rel) * acb_pkg::COEFS_PER_PAGE) + 12'(slot);
    d.bank  = in1;
    d.hit   = (in0 || in1) && (d.regaddr >= acb_pkg::FIRST_COEF_REG) &&
              (idx_w <= acb_pkg::LAST_INDEX);
    d.index = idx_w[7:0];
    d.lane  = d.regaddr[1:0];
  end

endmodule : acb_decode

// ### rtl/acb_coef_bank.sv
// paged register bank holding two 256-entry record filter coefficient sets
`timescale 1ns/100ps
module acb_coef_bank (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // host register access, one request a cycle
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [6:0]  acc_addr,
  input  wire logic [7:0]  acc_wdata,
  output logic      [7:0]  acc_rdata,
  output logic             acc_rvalid,
  // coefficient read port for the processing engine
  input  wire logic        cf_bank,
  input  wire logic [7:0]  cf_index,
  output logic      [23:0] cf_data,
  // page currently selected
  output logic      [7:0]  page_sel
);

  acb_pkg::acb_state_t s_reg;
  acb_pkg::acb_state_t s_next;

  acb_dec_if dif ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign dif.page    = s_reg.page;
  assign dif.regaddr = acc_addr;

  acb_decode u_decode (
    .d (dif.dec)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // reads use the page held before this request, so a page write and a
  // coefficient access must come in separate cycles
  always_comb
  begin
    s_next        = s_reg;
    s_next.rvalid = 1'b0;
    s_next.cdata  = s_reg.coef[cf_bank][cf_index];
    if (acc_valid && acc_write)
    begin
      if (acc_addr == acb_pkg::PAGE_SEL_REG[6:0])
      begin
        s_next.page = acc_wdata;
      end
      else if (dif.hit && dif.lane == acb_pkg::LANE_HI)
      begin
        s_next.coef[dif.bank][dif.index][23:16] = acc_wdata;
      end
      else if (dif.hit && dif.lane == acb_pkg::LANE_MID)
      begin
        s_next.coef[dif.bank][dif.index][15:8] = acc_wdata;
      end
      else if (dif.hit && dif.lane == acb_pkg::LANE_LO)
      begin
        s_next.coef[dif.bank][dif.index][7:0] = acc_wdata;
      end
      // reserved lane and unmapped registers: write dropped
    end
    else if (acc_valid)
    begin
      s_next.rvalid = 1'b1;
      if (acc_addr == acb_pkg::PAGE_SEL_REG[6:0])
      begin
        s_next.rdata = s_reg.page;
      end
      else if (dif.hit && dif.lane == acb_pkg::LANE_HI)
      begin
        s_next.rdata = s_reg.coef[dif.bank][dif.index][23:16];
      end
      else if (dif.hit && dif.lane == acb_pkg::LANE_MID)
      begin
        s_next.rdata = s_reg.coef[dif.bank][dif.index][15:8];
      end
      else if (dif.hit && dif.lane == acb_pkg::LANE_LO)
      begin
        s_next.rdata = s_reg.coef[dif.bank][dif.index][7:0];
      end
      else
      begin
        s_next.rdata = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register; ce low freezes everything
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg.page    <= acb_pkg::PAGE_RESET;
      s_reg.rdata   <= 8'h00;
      s_reg.rvalid  <= 1'b0;
      s_reg.cdata   <= 24'h000000;
      s_reg.coef[0] <= acb_pkg::BANK_RESET;
      s_reg.coef[1] <= acb_pkg::BANK_RESET;
    end
    else if (ce)
    begin
      s_reg <= s_next;
    end
  end

  assign acc_rdata  = s_reg.rdata;
  assign acc_rvalid = s_reg.rvalid;
  assign cf_data    = s_reg.cdata;
  assign page_sel   = s_reg.page;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_HIGH_BYTE_FIRST: assert property (
    @(posedge clk) disable iff (rst)
    (ce && acc_valid && acc_write && dif.hit && dif.lane == 2'h0)
      |=> s_reg.coef[$past(dif.bank)][$past(dif.index)][23:16]
          == $past(acc_wdata))
    else $error("high byte write did not land in bits 23:16");

  AST_LOW_BYTE_READ: assert property (
    @(posedge clk) disable iff (rst)
    (ce && acc_valid && !acc_write && dif.hit && dif.lane == 2'h2)
      |=> acc_rvalid &&
          acc_rdata == $past(s_reg.coef[dif.bank][dif.index][7:0]))
    else $error("lane 2 read did not return bits 7:0");

  AST_RSVD_READ_ZERO: assert property (
    @(posedge clk) disable iff (rst)
    (ce && acc_valid && !acc_write && acc_addr != 7'h00 &&
     (!dif.hit || dif.lane == 2'h3))
      |=> acc_rvalid && acc_rdata == 8'h00)
    else $error("reserved or unmapped read returned nonzero");

  AST_BANK0_LAST: assert property (
    @(posedge clk) disable iff (rst)
    (s_reg.page == 8'h10 && acc_addr == 7'h44)
      |-> dif.hit && !dif.bank && dif.index == 8'hFF)
    else $error("page 16 register 68 is not bank 0 index 255");

  AST_BANK1_FIRST: assert property (
    @(posedge clk) disable iff (rst)
    (s_reg.page == 8'h1A && acc_addr == 7'h08)
      |-> dif.hit && dif.bank && dif.index == 8'h00)
    else $error("page 26 register 8 is not bank 1 index 0");

  AST_RESET_DEFAULTS: assert property (
    @(posedge clk) disable iff (rst)
    $past(rst) |-> s_reg.coef[0][1] == 24'h011700 &&
                   s_reg.coef[1][3] == 24'h7DD300 &&
                   s_reg.coef[1][59] == 24'h07FFFF &&
                   s_reg.coef[0][0] == 24'h000000)
    else $error("coefficient defaults wrong after reset");

  AST_RESET_CLEAR_TAIL: assert property (
    @(posedge clk) disable iff (rst)
    $past(rst) |-> s_reg.coef[0][60] == 24'h000000 &&
                   s_reg.coef[1][255] == 24'h000000)
    else $error("upper coefficients not cleared after reset");

  AST_PAGE_WRITE: assert property (
    @(posedge clk) disable iff (rst)
    (ce && acc_valid && acc_write && acc_addr == 7'h00)
      |=> page_sel == $past(acc_wdata))
    else $error("page selector did not take the written value");

  // a frozen cycle must leave every output where it was
  AST_CE_FREEZE: assert property (
    @(posedge clk) disable iff (rst)
    !ce |=> $stable(page_sel) && $stable(acc_rvalid) &&
            $stable(acc_rdata) && $stable(cf_data))
    else $error("outputs moved while clock enable was low");

  AST_PAGE_READ: assert property (
    @(posedge clk) disable iff (rst)
    (ce && acc_valid && !acc_write && acc_addr == 7'h00)
      |=> acc_rvalid && acc_rdata == $past(page_sel))
    else $error("page selector read back wrong");

  // only a taken read raises the answer strobe
  AST_READ_PULSE: assert property (
    @(posedge clk) disable iff (rst)
    (ce && !(acc_valid && !acc_write)) |=> !acc_rvalid)
    else $error("read strobe high without a read");

  AST_MID_BYTE_WRITE: assert property (
    @(posedge clk) disable iff (rst)
    (ce && acc_valid && acc_write && dif.hit && dif.lane == 2'h1)
      |=> s_reg.coef[$past(dif.bank)][$past(dif.index)][15:8]
          == $past(acc_wdata))
    else $error("middle byte write did not land in bits 15:8");

  AST_LOW_BYTE_WRITE: assert property (
    @(posedge clk) disable iff (rst)
    (ce && acc_valid && acc_write && dif.hit && dif.lane == 2'h2)
      |=> s_reg.coef[$past(dif.bank)][$past(dif.index)][7:0]
          == $past(acc_wdata))
    else $error("low byte write did not land in bits 7:0");

  // the engine port hands over all 24 bits one cycle after the index
  AST_ENGINE_READ: assert property (
    @(posedge clk) disable iff (rst)
    ce |=> cf_data == $past(s_reg.coef[cf_bank][cf_index]))
    else $error("engine port returned the wrong coefficient");

  AST_RSVD_WRITE_DROP: assert property (
    @(posedge clk) disable iff (rst)
    (acc_valid && acc_write && dif.hit && dif.lane == 2'h3)
      |=> s_reg.coef == $past(s_reg.coef) && $stable(page_sel))
    else $error("reserved byte write changed the banks");

endmodule : acb_coef_bank

// ### verification/acb_coef_bank_test.sv
// self-checking bench for the record-path coefficient banks
`timescale 1ns/100ps
module acb_coef_bank_test;
  // ----------------------------------------------------------------
  // stimulus, observed outputs and counters
  // ----------------------------------------------------------------
  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic        ce         = 1'b1;
  logic        acc_valid  = 1'b0;
  logic        acc_write  = 1'b0;
  logic [6:0]  acc_addr   = 7'h00;
  logic [7:0]  acc_wdata  = 8'h00;
  logic        cf_bank    = 1'b0;
  logic [7:0]  cf_index   = 8'h00;
  logic [7:0]  acc_rdata;
  logic        acc_rvalid;
  logic [23:0] cf_data;
  logic [7:0]  page_sel;
  logic [7:0]  rb;
  int          err_count  = 0;
  int          num_checks = 0;

  acb_coef_bank i_dut (.clk(clk), .rst(rst), .ce(ce),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .cf_bank(cf_bank), .cf_index(cf_index), .cf_data(cf_data),
    .page_sel(page_sel));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // inputs always move 1 ns after the rising edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {acc_valid, acc_write, acc_addr, acc_wdata} = {2'b11, a, d};
    @(posedge clk);
    #1 acc_valid = 1'b0;
  endtask : wr

  // the answer is looked at in the one cycle that it stands
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 {acc_valid, acc_write, acc_addr} = {2'b10, a};
    @(posedge clk);
    #1 acc_valid = 1'b0;
    d = acc_rdata;
    check(acc_rvalid === 1'b1, "read not answered");
    @(posedge clk);
    #1 check(acc_rvalid === 1'b0, "read strobe too long");
    check(acc_rdata === d, "read data did not hold");
  endtask : rd

  task automatic chk_cf(input logic b, input logic [7:0] i,
                        input logic [23:0] exp);
    @(posedge clk);
    #1 {cf_bank, cf_index} = {b, i};
    @(posedge clk);
    #1 check(cf_data === exp, $sformatf("coef %0d/%0d wrong", b, i));
  endtask : chk_cf

  // reset contents, worked out independently of the design
  function automatic logic [23:0] def_coef(input int i);
    case (i)
      1, 2:    return 24'h011700;
      3:       return 24'h7DD300;
      4, 7, 12, 17, 22, 27, 36, 39, 44, 49, 54, 59: return 24'h07FFFF;
      default: return 24'h000000;
    endcase
  endfunction : def_coef

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check(page_sel === 8'h00, "page reset");
    for (int b = 0; b < 2; b++)
      for (int i = 0; i < 256; i++)
        chk_cf(b[0], i[7:0], def_coef(i));
    wr(7'h00, 8'h08);
    rd(7'h14, rb); check(rb === 8'h7D, "c3 hi");
    rd(7'h15, rb); check(rb === 8'hD3, "c3 mid");
    rd(7'h17, rb); check(rb === 8'h00, "c3 rsvd");
    $display("test reset done");
  endtask : t_reset

  task automatic t_page();
    wr(7'h00, 8'hA5);
    check(page_sel === 8'hA5, "page write");
    rd(7'h00, rb); check(rb === 8'hA5, "page readback");
    wr(7'h08, 8'h5A);
    rd(7'h08, rb); check(rb === 8'h00, "unmapped page");
    wr(7'h03, 8'h5A);
    rd(7'h03, rb); check(rb === 8'h00, "reserved reg 3");
    ce = 1'b0;
    wr(7'h00, 8'h11);
    ce = 1'b1;
    check(page_sel === 8'hA5, "write with ce low");
    $display("test page done");
  endtask : t_page

  // page, register, bank and index at layout corners
  task automatic t_layout();
    logic [7:0]  pg [6] = '{8'h08, 8'h09, 8'h10, 8'h1A, 8'h22, 8'h1E};
    logic [6:0]  rg [6] = '{7'h7C, 7'h08, 7'h44, 7'h08, 7'h44, 7'h08};
    logic [7:0]  ix [6] = '{8'd29, 8'd30, 8'd255, 8'd0, 8'd255, 8'd120};
    logic        bk [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [23:0] v;
    for (int k = 0; k < 6; k++)
    begin
      v = {ix[k], ~ix[k], 8'hC0 | 8'(k)};
      wr(7'h00, pg[k]);
      wr(rg[k], v[23:16]);
      wr(rg[k] + 7'h01, v[15:8]);
      wr(rg[k] + 7'h02, v[7:0]);
      chk_cf(bk[k], ix[k], v);
      rd(rg[k], rb); check(rb === v[23:16], "hi byte");
      rd(rg[k] + 7'h02, rb); check(rb === v[7:0], "lo byte");
    end
    $display("test layout done");
  endtask : t_layout

  task automatic t_rsvd();
    wr(7'h00, 8'h22);
    wr(7'h47, 8'hFF);
    rd(7'h47, rb); check(rb === 8'h00, "reserved byte");
    chk_cf(1'b1, 8'd255, 24'hFF00C4);
    wr(7'h48, 8'h77);
    rd(7'h48, rb); check(rb === 8'h00, "past last slot");
    wr(7'h00, 8'h11);
    wr(7'h08, 8'h77);
    rd(7'h08, rb); check(rb === 8'h00, "page 17");
    $display("test reserved done");
  endtask : t_rsvd

  // a second reset restores defaults over written contents
  task automatic t_rerun();
    wr(7'h00, 8'h08);
    wr(7'h18, 8'h12);
    chk_cf(1'b0, 8'd4, 24'h12FFFF);
    @(posedge clk);
    #1 rst = 1'b1;
    #5 check(page_sel === 8'h00, "page held in reset");
    check(cf_data === 24'h000000, "engine data in reset");
    @(posedge clk);
    #1 rst = 1'b0;
    chk_cf(1'b0, 8'd4, 24'h07FFFF);
    chk_cf(1'b0, 8'd29, 24'h000000);
    chk_cf(1'b1, 8'd255, 24'h000000);
    check(page_sel === 8'h00, "page after reset");
    $display("test rerun done");
  endtask : t_rerun

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_page();
    t_layout();
    t_rsvd();
    t_rerun();
    end_of_test();
  end

  // the run needs about 1200 cycles; allow well over that
  initial
  begin
    #(25 * 8000);
    err_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : acb_coef_bank_test
